// >>> hdl/rmc_params.svh
/*
  offsets, field positions, reset values and timing counts of the
  radio configuration register bank; assumes one 200 MHz clock.
*/
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH

`define RMC_CLK_MHZ        200
`define RMC_NUM_REGS       10

// register offsets
`define RMC_OFF_SPC_EXP    6'h13
`define RMC_OFF_SPC_MANT   6'h14
`define RMC_OFF_DEV        6'h15
`define RMC_OFF_FSM_RXTO   6'h16
`define RMC_OFF_FSM_NEXT   6'h17
`define RMC_OFF_FSM_CAL    6'h18
`define RMC_OFF_FOC        6'h19
`define RMC_OFF_BSYNC      6'h1a
`define RMC_OFF_AGC_LIM    6'h1b
`define RMC_OFF_AGC_CS     6'h1c

// reset values
`define RMC_RST_SPC_EXP    8'h02
`define RMC_RST_SPC_MANT   8'hf8
`define RMC_RST_DEV        8'h47
`define RMC_RST_FSM_RXTO   8'h07
`define RMC_RST_FSM_NEXT   8'h30
`define RMC_RST_FSM_CAL    8'h04
`define RMC_RST_FOC        8'h36
`define RMC_RST_BSYNC      8'h6c
`define RMC_RST_AGC_LIM    8'h03
`define RMC_RST_AGC_CS     8'h40

// writable bit masks, other bits read zero
`define RMC_MSK_SPC_EXP    8'h03
`define RMC_MSK_SPC_MANT   8'hff
`define RMC_MSK_DEV        8'h77
`define RMC_MSK_FSM_RXTO   8'h1f
`define RMC_MSK_FSM_NEXT   8'h3f
`define RMC_MSK_FSM_CAL    8'h3f
`define RMC_MSK_FOC        8'h3f
`define RMC_MSK_BSYNC      8'hff
`define RMC_MSK_AGC_LIM    8'hff
`define RMC_MSK_AGC_CS     8'h7f

// field positions
`define RMC_BIT_RX_END_CS  4
`define RMC_BIT_XOSC_ON    0
`define RMC_BIT_LOOP_GATE  5
`define RMC_BIT_FOC_POST   2
`define RMC_BIT_KI_POST    3
`define RMC_BIT_KP_POST    2
`define RMC_BIT_LNA_PRIO   6

// timing counts, top digital gain step and absolute threshold off code
`define RMC_RIPPLE_BITS    6
`define RMC_OOK_CS_SYMBOLS 4'd8
`define RMC_CAL_EVERY      2'd3
`define RMC_DVGA_TOP_STEP  3'd7
`define RMC_ABS_THR_OFF    4'h8

`endif

// >>> hdl/rmc_pkg.sv
/*
  types shared by the radio configuration register bank;
  assumes nothing beyond the compiler.
*/
`default_nettype none

package rmc_pkg;
  typedef enum logic [1:0] {
    RMC_GO_IDLE, RMC_GO_SYNTH_ON, RMC_GO_TX, RMC_GO_RX
  } rmc_next_t;
  typedef enum logic [1:0] {
    RMC_CAL_NEVER, RMC_CAL_ON_START, RMC_CAL_ON_RETURN, RMC_CAL_EVERY_4TH
  } rmc_cal_t;
  typedef enum logic [1:0] {
    RMC_CCA_ALWAYS, RMC_CCA_RSSI, RMC_CCA_NO_PKT, RMC_CCA_BOTH
  } rmc_cca_t;
endpackage

`default_nettype wire

// >>> hdl/rmc_config_regs.sv
/*
  radio configuration register bank: register storage, field decode
  and the small control pieces driven by it (spacing word, deviation,
  clear channel, calibration requests, power-on timeout, carrier sense).
  assumes the serial host port logic and the datapath run on clk;
  only the oscillator-settled level comes from outside and is synchronised.
*/
//
// Behaviour
// - spacing = (256+mantissa)<<exponent, times channel, added to base frequency
// - fsk transmit deviates minus for zero, plus for one; none under on-off keying
// - end receive when carrier sense is low; ook times out without sense in 8 symbols
// - clear channel: always, rssi low, no packet, or both
// - after receive go idle, synth-on, transmit or stay in receive
// - after transmit go idle, synth-on, stay transmitting, or receive
// - calibrate never (strobe only), on start, on return, every fourth return
// - chip ready low after 1, 16, 64 or 256 six-bit counter expiries
// - oscillator stable and chip ready assert in the same cycle
// - force bit keeps oscillator running in sleep
// - gate bit freezes both loops until carrier sense rises
// - freq loop gain K..4K before sync; after sync same or K/2
// - freq offset saturation off, bw/8, bw/4 or bw/2
// - clock recovery gains one to four times base before sync
// - after sync keep gains, or half integral and base proportional
// - rate offset limit off, 3.125, 6.25 or 12.5 percent
// - exclude 0 to 3 highest digital gain steps
// - front gain cap in eight levels; amplitude target 24 to 42 dB
// - priority bit lowers first stage first, else second stage first
// - carrier sense on 6/10/14 dB rise or absolute threshold, -8 off
`include "rmc_params.svh"
`default_nettype none

module rmc_config_regs
  import rmc_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // register port from the serial host logic
  input  wire logic               regWrEn,
  input  wire logic               regRdEn,
  input  wire logic [5:0]         regAddr,
  input  wire logic [7:0]         regWrData,
  output logic      [7:0]         regRdData,
  // synthesizer
  input  wire logic [23:0]        baseFreq,
  input  wire logic [7:0]         channelNumber,
  output logic      [26:0]        synthWord,
  // modulator
  input  wire logic               modOok,
  input  wire logic               txDataBit,
  output logic signed [11:0]      devOffset,
  // receive status
  input  wire logic               inRx,
  input  wire logic               symbolTick,
  input  wire logic               rssiBelowThr,
  input  wire logic               receivingPkt,
  input  wire logic               syncFound,
  input  wire logic signed [7:0]  rssiDb,
  input  wire logic [7:0]         rssiRiseDb,
  output logic                    carrierSense,
  output logic                    rxTerminate,
  output logic                    clearChannel,
  // state machine hints
  input  wire logic               calibrateStrobe,
  input  wire logic               idleToActive,
  input  wire logic               autoReturnIdle,
  input  wire logic               inSleep,
  output rmc_next_t               afterRxState,
  output rmc_next_t               afterTxState,
  output logic                    calRequest,
  output logic                    oscRun,
  // power-on
  input  wire logic               xoscSettled,
  output logic                    chipReadyN,
  output logic                    xoscStable,
  // demodulator loops
  output logic                    loopsFrozen,
  output logic      [3:0]         freqCompGainHalfK,
  output logic      [1:0]         freqCompSatShift,
  output logic                    freqCompOff,
  output logic      [3:0]         kiHalf,
  output logic      [2:0]         kpGain,
  output logic      [2:0]         rateLimitSteps,
  // gain control
  output logic      [2:0]         digitalGainMaxStep,
  output logic      [2:0]         frontGainCap,
  output logic      [5:0]         amplitudeTargetDb,
  output logic                    gainReduceFirstStage
);

  localparam int N = `RMC_NUM_REGS;
  localparam logic [5:0] OFFS [N] = '{`RMC_OFF_SPC_EXP, `RMC_OFF_SPC_MANT,
    `RMC_OFF_DEV, `RMC_OFF_FSM_RXTO, `RMC_OFF_FSM_NEXT, `RMC_OFF_FSM_CAL,
    `RMC_OFF_FOC, `RMC_OFF_BSYNC, `RMC_OFF_AGC_LIM, `RMC_OFF_AGC_CS};
  localparam logic [7:0] RSTS [N] = '{`RMC_RST_SPC_EXP, `RMC_RST_SPC_MANT,
    `RMC_RST_DEV, `RMC_RST_FSM_RXTO, `RMC_RST_FSM_NEXT, `RMC_RST_FSM_CAL,
    `RMC_RST_FOC, `RMC_RST_BSYNC, `RMC_RST_AGC_LIM, `RMC_RST_AGC_CS};
  localparam logic [7:0] MSKS [N] = '{`RMC_MSK_SPC_EXP, `RMC_MSK_SPC_MANT,
    `RMC_MSK_DEV, `RMC_MSK_FSM_RXTO, `RMC_MSK_FSM_NEXT, `RMC_MSK_FSM_CAL,
    `RMC_MSK_FOC, `RMC_MSK_BSYNC, `RMC_MSK_AGC_LIM, `RMC_MSK_AGC_CS};

  logic [7:0] regs [N];

  function automatic logic [3:0] regIndex(input logic [5:0] a);
    regIndex = 4'hf;
    for (int i = 0; i < N; i++) begin
      if (a == OFFS[i]) regIndex = 4'(i);
    end
  endfunction

  // storage; masking keeps unused bits at zero so reads need no extra gating
  for (genvar g = 0; g < N; g++) begin : gRegs
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) regs[g] <= RSTS[g];
      else if (regWrEn && regIndex(regAddr) == 4'(g)) regs[g] <= regWrData & MSKS[g];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) regRdData <= 8'h00;
    else if (regRdEn) regRdData <= (regIndex(regAddr) < 4'(N)) ? regs[regIndex(regAddr)] : 8'h00;
  end

  // field views
  wire logic [1:0] spacingExponent = regs[0][1:0];
  wire logic [7:0] spacingMantissa = regs[1];
  wire logic [2:0] devExp          = regs[2][6:4];
  wire logic [2:0] devMant         = regs[2][2:0];
  wire logic       rxEndOnCs       = regs[3][`RMC_BIT_RX_END_CS];
  wire logic [1:0] clearChanSel    = regs[4][5:4];
  wire logic [1:0] calSel          = regs[5][5:4];
  wire logic [1:0] poSel           = regs[5][3:2];
  wire logic       xoscForceOn     = regs[5][`RMC_BIT_XOSC_ON];
  wire logic       loopGate        = regs[6][`RMC_BIT_LOOP_GATE];
  wire logic [1:0] focPre          = regs[6][4:3];
  wire logic       focPost         = regs[6][`RMC_BIT_FOC_POST];
  wire logic [1:0] focSat          = regs[6][1:0];
  wire logic [1:0] kiPre           = regs[7][7:6];
  wire logic [1:0] kpPre           = regs[7][5:4];
  wire logic       kiPost          = regs[7][`RMC_BIT_KI_POST];
  wire logic       kpPost          = regs[7][`RMC_BIT_KP_POST];
  wire logic [1:0] rateSat         = regs[7][1:0];
  wire logic [1:0] dvgaCut         = regs[8][7:6];
  wire logic [2:0] lnaCap          = regs[8][5:3];
  wire logic [2:0] magnTarget      = regs[8][2:0];
  wire logic       lnaPrio         = regs[9][`RMC_BIT_LNA_PRIO];
  wire logic [1:0] relThr          = regs[9][5:4];
  wire logic [3:0] absThr          = regs[9][3:0];

  // channel spacing in units of fxosc/2^18, base shifted up from fxosc/2^16
  wire logic [11:0] spacingStep = 12'({1'b1, spacingMantissa}) << spacingExponent;
  wire logic [19:0] spacingTotal = 20'(spacingStep * channelNumber);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) synthWord <= 27'h0000000;
    else synthWord <= 27'({baseFreq, 2'b00}) + 27'(spacingTotal);
  end

  // deviation in units of fxosc/2^17
  wire logic [10:0] devStep = 11'({1'b1, devMant}) << devExp;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) devOffset <= 12'sh000;
    else if (modOok) devOffset <= 12'sh000;
    else devOffset <= txDataBit ? $signed({1'b0, devStep}) : -$signed({1'b0, devStep});
  end

  // carrier sense
  function automatic logic [5:0] targetDb(input logic [2:0] s);
    unique case (s)
      3'h0: targetDb = 6'd24;
      3'h1: targetDb = 6'd27;
      3'h2: targetDb = 6'd30;
      3'h3: targetDb = 6'd33;
      3'h4: targetDb = 6'd36;
      3'h5: targetDb = 6'd38;
      3'h6: targetDb = 6'd40;
      3'h7: targetDb = 6'd42;
    endcase
  endfunction

  logic [7:0] relLimit;
  always_comb begin
    unique case (relThr)
      2'h0: relLimit = 8'hff;
      2'h1: relLimit = 8'd6;
      2'h2: relLimit = 8'd10;
      2'h3: relLimit = 8'd14;
    endcase
  end

  wire logic signed [8:0] absLimit =
    $signed({3'b000, targetDb(magnTarget)}) + 9'($signed(absThr));
  wire logic absHit = (absThr != `RMC_ABS_THR_OFF) && ($signed({rssiDb[7], rssiDb}) >= absLimit);
  wire logic relHit = (relThr != 2'h0) && (rssiRiseDb >= relLimit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) carrierSense <= 1'b0;
    else carrierSense <= absHit || relHit;
  end

  // receive termination; the ook window counts symbols while sense is low and clears whenever sense is high
  logic [3:0] symCount;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) symCount <= 4'h0;
    else if (!inRx || carrierSense) symCount <= 4'h0;
    else if (symbolTick && symCount != `RMC_OOK_CS_SYMBOLS) symCount <= symCount + 4'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rxTerminate <= 1'b0;
    else rxTerminate <= inRx && rxEndOnCs && (modOok ?
      (symCount == `RMC_OOK_CS_SYMBOLS) : !carrierSense);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) clearChannel <= 1'b1;
    else begin
      unique case (rmc_cca_t'(clearChanSel))
        RMC_CCA_ALWAYS: clearChannel <= 1'b1;
        RMC_CCA_RSSI:   clearChannel <= rssiBelowThr;
        RMC_CCA_NO_PKT: clearChannel <= !receivingPkt;
        RMC_CCA_BOTH:   clearChannel <= rssiBelowThr && !receivingPkt;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      afterRxState <= RMC_GO_IDLE;
      afterTxState <= RMC_GO_IDLE;
    end else begin
      afterRxState <= rmc_next_t'(regs[4][3:2]);
      afterTxState <= rmc_next_t'(regs[4][1:0]);
    end
  end

  // calibration; returns are counted only while in every-fourth mode
  logic [1:0] returnCount;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) returnCount <= 2'h0;
    else if (calSel != RMC_CAL_EVERY_4TH) returnCount <= 2'h0;
    else if (autoReturnIdle) returnCount <= returnCount + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) calRequest <= 1'b0;
    else begin
      unique case (rmc_cal_t'(calSel))
        RMC_CAL_NEVER:     calRequest <= calibrateStrobe;
        RMC_CAL_ON_START:  calRequest <= calibrateStrobe || idleToActive;
        RMC_CAL_ON_RETURN: calRequest <= calibrateStrobe || autoReturnIdle;
        RMC_CAL_EVERY_4TH: calRequest <= calibrateStrobe ||
          (autoReturnIdle && returnCount == `RMC_CAL_EVERY);
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oscRun <= 1'b1;
    else oscRun <= !inSleep || xoscForceOn;
  end

  // power-on timeout; settled level is asynchronous to clk
  logic xoscSync1, xoscOk;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xoscSync1 <= 1'b0;
      xoscOk    <= 1'b0;
    end else begin
      xoscSync1 <= xoscSettled;
      xoscOk    <= xoscSync1;
    end
  end

  logic [`RMC_RIPPLE_BITS-1:0] ripple;
  logic [8:0] expireCount;
  logic [8:0] expireTarget;
  always_comb begin
    unique case (poSel)
      2'h0: expireTarget = 9'd1;
      2'h1: expireTarget = 9'd16;
      2'h2: expireTarget = 9'd64;
      2'h3: expireTarget = 9'd256;
    endcase
  end
  wire logic poDone = expireCount >= expireTarget;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ripple      <= '0;
      expireCount <= 9'h000;
    end else if (!xoscOk) begin
      ripple      <= '0;
      expireCount <= 9'h000;
    end else if (!poDone) begin
      ripple <= ripple + 1'b1;
      if (&ripple) expireCount <= expireCount + 9'h001;
    end
  end

  // both come from one term so neither can lead the other
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chipReadyN <= 1'b1;
      xoscStable <= 1'b0;
    end else begin
      chipReadyN <= !(xoscOk && poDone);
      xoscStable <= xoscOk && poDone;
    end
  end

  // demodulator loops and gain control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loopsFrozen          <= 1'b1;
      freqCompGainHalfK    <= 4'h6;
      freqCompSatShift     <= 2'h2;
      freqCompOff          <= 1'b0;
      kiHalf               <= 4'h4;
      kpGain               <= 3'h3;
      rateLimitSteps       <= 3'h0;
      digitalGainMaxStep   <= `RMC_DVGA_TOP_STEP;
      frontGainCap         <= 3'h0;
      amplitudeTargetDb    <= 6'd33;
      gainReduceFirstStage <= 1'b1;
    end else begin
      loopsFrozen <= loopGate && !carrierSense;
      freqCompGainHalfK <= (syncFound && focPost) ? 4'h1 :
        {3'({1'b0, focPre} + 3'h1), 1'b0};
      freqCompOff <= (focSat == 2'h0);
      freqCompSatShift <= (focSat == 2'h0) ? 2'h0 : 2'(2'h3 - focSat + 2'h1);
      kiHalf <= (syncFound && kiPost) ? 4'h1 : {3'({1'b0, kiPre} + 3'h1), 1'b0};
      kpGain <= (syncFound && kpPost) ? 3'h1 : 3'({1'b0, kpPre} + 3'h1);
      rateLimitSteps <= (rateSat == 2'h0) ? 3'h0 : 3'(3'h1 << (rateSat - 2'h1));
      digitalGainMaxStep <= `RMC_DVGA_TOP_STEP - {1'b0, dvgaCut};
      frontGainCap <= lnaCap;
      amplitudeTargetDb <= targetDb(magnTarget);
      gainReduceFirstStage <= lnaPrio;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sPoRise;
    !xoscStable ##1 xoscStable;
  endsequence

  ready_stable_pair_a: assert property (chipReadyN == !xoscStable)
    else $error("chip ready and oscillator stable disagree");
  power_on_timeout_select_done_a: assert property (sPoRise |-> $past(poDone) && $past(xoscOk))
    else $error("chip ready before timeout expired");
  ook_no_dev_a: assert property (modOok |=> devOffset == 12'sh000)
    else $error("deviation under on-off keying");
  dev_sign_a: assert property (!modOok && txDataBit |=> devOffset > 12'sh000)
    else $error("deviation sign wrong for one");
  cca_both_a: assert property (clearChanSel == 2'h3 && receivingPkt
    |=> !clearChannel)
    else $error("clear channel during packet");
  loop_gate_a: assert property (loopGate && !carrierSense ##1 $stable(loopGate)
    |-> loopsFrozen)
    else $error("loops not frozen before carrier sense");
  cal_never_a: assert property (calSel == 2'h0 && !calibrateStrobe |=> !calRequest)
    else $error("calibration without strobe");
  osc_sleep_a: assert property (inSleep && !xoscForceOn |=> !oscRun)
    else $error("oscillator left running in sleep");
  cs_off_a: assert property (relThr == 2'h0 && absThr == `RMC_ABS_THR_OFF
    |=> !carrierSense)
    else $error("carrier sense while disabled");
  unused_zero_a: assert property (regRdEn && regAddr == `RMC_OFF_FSM_RXTO
    |=> regRdData[7:5] == 3'h0)
    else $error("unused bits read nonzero");
  foc_post_a: assert property (syncFound && focPost |=> freqCompGainHalfK == 4'h1)
    else $error("post sync gain not half K");

endmodule

`default_nettype wire

// >>> test/rmc_host_model.sv
/*
  host side of the register port: one-cycle write and read strobes,
  one request at a time. assumes the bank samples them on clk.
*/
`include "rmc_params.svh"
`default_nettype none

module rmc_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output var  logic       regWrEn,
  output var  logic       regRdEn,
  output var  logic [5:0] regAddr,
  output var  logic [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 6'h00;
    regWrData = 8'h00;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask

  // data is registered at the strobe edge, so look half a cycle later
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask

  // oscillator held in sleep: give the regulator time before ready
  task automatic safeOsc();
    wr(`RMC_OFF_FSM_CAL, 8'h09);
  endtask

  // offset compensation is unsupported under on-off keying
  task automatic ookPrep();
    wr(`RMC_OFF_FOC, 8'h30);
  endtask
endmodule

`default_nettype wire

// >>> test/testbench.sv
/*
  self-checking bench for the radio configuration register bank.
  assumes the bank and the host model are compiled before it.
*/
`include "rmc_params.svh"
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic regWrEn, regRdEn, modOok, txDataBit, inRx, symbolTick, rssiBelowThr, receivingPkt;
  logic syncFound, calibrateStrobe, idleToActive, autoReturnIdle, inSleep, xoscSettled;
  logic carrierSense, rxTerminate, clearChannel, calRequest, oscRun, chipReadyN, xoscStable;
  logic loopsFrozen, freqCompOff, gainReduceFirstStage;
  logic [1:0] afterRxState, afterTxState, freqCompSatShift;
  logic [2:0] kpGain, rateLimitSteps, digitalGainMaxStep, frontGainCap;
  logic [3:0] freqCompGainHalfK, kiHalf;
  logic [5:0] regAddr, amplitudeTargetDb;
  logic [7:0] regWrData, regRdData, channelNumber, rssiRiseDb, rd;
  logic [23:0] baseFreq;
  logic [26:0] synthWord;
  logic signed [7:0] rssiDb;
  logic signed [11:0] devOffset;
  int fails = 0;
  int nChecks = 0;
  int n;
  int thr [4] = '{255, 6, 10, 14};
  int tgt [8] = '{24, 27, 30, 33, 36, 38, 40, 42};
  logic [2:0] rate [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic [3:0] cca [4] = '{4'hf, 4'hc, 4'h5, 4'h4};
  logic [2:0] calExp [4] = '{3'h4, 3'h6, 3'h5, 3'h4};
  logic [7:0] rsts [10] = '{`RMC_RST_SPC_EXP, `RMC_RST_SPC_MANT, `RMC_RST_DEV,
    `RMC_RST_FSM_RXTO, `RMC_RST_FSM_NEXT, `RMC_RST_FSM_CAL, `RMC_RST_FOC, `RMC_RST_BSYNC,
    `RMC_RST_AGC_LIM, `RMC_RST_AGC_CS};
  logic [7:0] msks [10] = '{`RMC_MSK_SPC_EXP, `RMC_MSK_SPC_MANT, `RMC_MSK_DEV,
    `RMC_MSK_FSM_RXTO, `RMC_MSK_FSM_NEXT, `RMC_MSK_FSM_CAL, `RMC_MSK_FOC, `RMC_MSK_BSYNC,
    `RMC_MSK_AGC_LIM, `RMC_MSK_AGC_CS};

  always #2.5 clk = ~clk;

  rmc_host_model host (.clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData);

  rmc_config_regs dut (
    .clk, .rst_n(rstN), .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .baseFreq,
    .channelNumber, .synthWord, .modOok, .txDataBit, .devOffset, .inRx, .symbolTick,
    .rssiBelowThr, .receivingPkt, .syncFound, .rssiDb, .rssiRiseDb, .carrierSense,
    .rxTerminate, .clearChannel, .calibrateStrobe, .idleToActive, .autoReturnIdle, .inSleep,
    .afterRxState, .afterTxState, .calRequest, .oscRun, .xoscSettled, .chipReadyN,
    .xoscStable, .loopsFrozen, .freqCompGainHalfK, .freqCompSatShift, .freqCompOff, .kiHalf,
    .kpGain, .rateLimitSteps, .digitalGainMaxStep, .frontGainCap, .amplitudeTargetDb,
    .gainReduceFirstStage
  );

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", s, e, g);
    end
  endtask

  task automatic finishTest();
    if (fails == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // outputs may lag a registered carrier sense by one more cycle
  task automatic st();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic tick();
    @(posedge clk);
    symbolTick <= 1'b1;
    @(posedge clk);
    symbolTick <= 1'b0;
  endtask

  // k: 0 auto return, 1 idle to active, 2 strobe; c counts request pulses
  task automatic pls(input int k, output int c);
    @(posedge clk);
    {calibrateStrobe, idleToActive, autoReturnIdle} <= 3'(1 << k);
    @(posedge clk);
    {calibrateStrobe, idleToActive, autoReturnIdle} <= 3'h0;
    c = 0;
    repeat (4) begin
      @(negedge clk);
      c += int'(calRequest === 1'b1);
    end
  endtask

  task automatic por(input int x);
    int c;
    logic early;
    @(posedge clk);
    xoscSettled <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("readyRestart", 1, chipReadyN);
    c = 0;
    early = 1'b0;
    xoscSettled <= 1'b1;
    @(negedge clk);
    while (chipReadyN !== 1'b0 && c < 20000) begin
      early |= (xoscStable !== 1'b0);
      @(negedge clk);
      c++;
    end
    `CHK("readyDelay", 1, c >= x * 64 && c <= x * 64 + 6);
    `CHK("stableWithReady", 2'h2, {xoscStable, early});
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    finishTest();
  end

  initial begin
    {modOok, txDataBit, inRx, symbolTick, rssiBelowThr, receivingPkt, syncFound} = '0;
    {calibrateStrobe, idleToActive, autoReturnIdle, inSleep, xoscSettled} = '0;
    baseFreq = 24'h100000;
    channelNumber = 8'h03;
    rssiDb = -8'sh64;
    rssiRiseDb = 8'h00;
    repeat (20) @(posedge clk);
    rstN <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      host.rd(6'(`RMC_OFF_SPC_EXP + i), rd);
      `CHK("resetValue", rsts[i], rd);
    end
    por(16);
    `CHK("synth", 27'h400000 + 27'd6048, synthWord);
    host.wr(`RMC_OFF_SPC_EXP, 8'h03);
    host.wr(`RMC_OFF_SPC_MANT, 8'hff);
    @(posedge clk);
    baseFreq <= 24'h3fffff;
    channelNumber <= 8'hff;
    st();
    `CHK("synthMax", 27'hfffffc + 27'd1042440, synthWord);
    `CHK("devZero", -12'sd240, devOffset);
    @(posedge clk);
    txDataBit <= 1'b1;
    st();
    `CHK("devOne", 12'sd240, devOffset);
    host.wr(`RMC_OFF_DEV, 8'h00);
    st();
    `CHK("devMin", 12'sd8, devOffset);
    host.ookPrep();
    @(posedge clk);
    modOok <= 1'b1;
    st();
    `CHK("devOok", 0, devOffset);
    host.wr(`RMC_OFF_FSM_RXTO, 8'h17);
    @(posedge clk);
    inRx <= 1'b1;
    repeat (7) tick();
    st();
    `CHK("ookEarly", 0, rxTerminate);
    `CHK("loopsHeld", 1, loopsFrozen);
    tick();
    st();
    `CHK("ookTimeout", 1, rxTerminate);
    @(posedge clk);
    modOok <= 1'b0;
    st();
    `CHK("endNoSense", 1, rxTerminate);
    @(posedge clk);
    rssiDb <= 8'sh40;
    st();
    `CHK("endOnSense", 0, rxTerminate);
    `CHK("loopsFree", 0, loopsFrozen);
    host.wr(`RMC_OFF_FOC, 8'h10);
    @(posedge clk);
    rssiDb <= -8'sh64;
    st();
    `CHK("loopsNoGate", 0, loopsFrozen);
    for (int r = 0; r < 4; r++) begin
      host.wr(`RMC_OFF_AGC_CS, 8'(8'h48 | (r << 4)));
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        rssiRiseDb <= 8'(thr[r] - 1 + k);
        st();
        `CHK("relThr", r > 0 && k == 1, carrierSense);
      end
    end
    `CHK("lnaFirst", 1, gainReduceFirstStage);
    host.wr(`RMC_OFF_AGC_CS, 8'h0f);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      rssiRiseDb <= 8'h00;
      rssiDb <= 8'(31 + k);
      st();
      `CHK("absThr", k, carrierSense);
    end
    `CHK("lnaLast", 0, gainReduceFirstStage);
    for (int m = 0; m < 4; m++) begin
      host.wr(`RMC_OFF_FSM_NEXT, 8'((m << 4) | (m << 2) | m));
      for (int j = 0; j < 4; j++) begin
        @(posedge clk);
        {rssiBelowThr, receivingPkt} <= 2'(j);
        st();
        `CHK("clearChan", cca[m][j], clearChannel);
      end
      `CHK("afterRx", m, afterRxState);
      `CHK("afterTx", m, afterTxState);
    end
    for (int m = 0; m < 4; m++) begin
      host.wr(`RMC_OFF_FSM_CAL, 8'((m << 4) | 4));
      for (int k = 0; k < 3; k++) begin
        pls(k, n);
        `CHK("calReq", calExp[m][k], n);
      end
    end
    for (int i = 0; i < 3; i++) begin
      pls(0, n);
      `CHK("calFourth", i == 2, n);
    end
    host.safeOsc();
    @(posedge clk);
    inSleep <= 1'b1;
    st();
    `CHK("oscKept", 1, oscRun);
    host.wr(`RMC_OFF_FSM_CAL, 8'h08);
    st();
    `CHK("oscStops", 0, oscRun);
    @(posedge clk);
    inSleep <= 1'b0;
    por(64);
    host.wr(`RMC_OFF_FSM_CAL, 8'h00);
    por(1);
    host.wr(`RMC_OFF_FSM_CAL, 8'h0c);
    por(256);
    for (int v = 0; v < 4; v++) begin
      host.wr(`RMC_OFF_FOC, 8'((v << 3) | v));
      host.wr(`RMC_OFF_BSYNC, 8'((v << 6) | (v << 4) | v));
      st();
      `CHK("focGain", 2 * v + 2, freqCompGainHalfK);
      `CHK("focSat", {v == 0, 2'(4 - v)}, {freqCompOff, freqCompSatShift});
      `CHK("bsPre", {4'(2 * v + 2), 3'(v + 1), rate[v]},
           {kiHalf, kpGain, rateLimitSteps});
    end
    @(posedge clk);
    syncFound <= 1'b1;
    host.wr(`RMC_OFF_FOC, 8'h1c);
    host.wr(`RMC_OFF_BSYNC, 8'hfc);
    st();
    `CHK("postHalf", {4'h1, 4'h1, 3'h1}, {freqCompGainHalfK, kiHalf, kpGain});
    host.wr(`RMC_OFF_FOC, 8'h18);
    host.wr(`RMC_OFF_BSYNC, 8'hf0);
    st();
    `CHK("postSame", {4'h8, 4'h8, 3'h4}, {freqCompGainHalfK, kiHalf, kpGain});
    for (int v = 0; v < 8; v++) begin
      host.wr(`RMC_OFF_AGC_LIM, 8'((v << 6) | (v << 3) | v));
      st();
      `CHK("gainCaps", {3'(7 - v % 4), 3'(v), 6'(tgt[v])},
           {digitalGainMaxStep, frontGainCap, amplitudeTargetDb});
    end
    for (int i = 0; i < 12; i++) begin
      host.wr(6'(`RMC_OFF_SPC_EXP + i), 8'hff);
      host.rd(6'(`RMC_OFF_SPC_EXP + i), rd);
      `CHK("readBack", i < 10 ? msks[i] : 8'h00, rd);
    end
    finishTest();
  end
endmodule

`default_nettype wire
